// ### adc_channel_sequence_select_tb.sv
// Self-checking testbench for the conversion sequence selector.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_sequence_select_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic chip_select_n, read_strobe_n, write_strobe_n;
    logic [3:0] bus_line_in;
    logic conversion_start_n = 1'b1;
    logic source_select = 1'b0;
    logic [3:0] hw_channel_pick = 4'h0;
    logic [11:0] sar_result = 12'h000;
    logic sequence_active, result_valid;
    logic [3:0] latched_selection, sequence_channel_mask;
    logic [1:0] converting_channel, result_channel;
    logic [11:0] result_code;
    int n_mismatch = 0;
    int comparisons = 0;
    int exp_q[$];
    always #2 core_clk = ~core_clk;
    host_bus_model host_bus_model_inst (.core_clk, .chip_select_n, .read_strobe_n,
        .write_strobe_n, .bus_line(bus_line_in));
    seq_select seq_select_inst (.core_clk, .nrst, .chip_select_n, .read_strobe_n,
        .write_strobe_n, .conversion_start_n, .source_select, .hw_channel_pick, .bus_line_in,
        .sar_result, .sequence_active, .latched_selection, .sequence_channel_mask,
        .converting_channel, .result_valid, .result_channel, .result_code);
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic finish_test;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // The analog result is held for a whole channel and renewed after each result.
    always @(negedge core_clk) begin
        if (result_valid === 1'b1) begin
            check("channel", 12'(exp_q.size() > 0 ? exp_q.pop_front() : 9), 12'(result_channel));
            check("code", sar_result ^ 12'h800, result_code);
            sar_result <= 12'($urandom);
        end
    end
    task automatic run_seq(input logic src, input logic [3:0] sel);
        source_select = src;
        if (src) host_bus_model_inst.write_mask(sel, 1'b0, 1'b1);
        else hw_channel_pick = sel;
        for (int i = 0; i < 4; i++)
            if (sel[i]) exp_q.push_back(i);
        repeat (4) @(negedge core_clk);
        conversion_start_n = 1'b0;
        repeat (4) @(negedge core_clk);
        conversion_start_n = 1'b1;
        for (int t = 0; t < 12 && sequence_active !== 1'b1; t++) @(negedge core_clk);
        check("active", 12'h001, 12'(sequence_active));
        check("latched", 12'(sel), 12'(latched_selection));
        if (sel != 4'h0) check("first channel", 12'(exp_q[0]), 12'(converting_channel));
        // Both sources change mid-run; only a later sequence may pick this up.
        hw_channel_pick = ~sel;
        host_bus_model_inst.write_mask(~sel, 1'b0, 1'b1);
        // A start edge inside a running sequence must neither relatch nor add results.
        if (sequence_active === 1'b1) begin
            conversion_start_n = 1'b0;
            repeat (4) @(negedge core_clk);
            conversion_start_n = 1'b1;
            repeat (4) @(negedge core_clk);
        end
        if (sequence_active === 1'b1) check("held", 12'(sel), 12'(latched_selection));
        for (int t = 0; t < 2000 && sequence_active !== 1'b0; t++) @(negedge core_clk);
        @(negedge core_clk);
        check("missing results", 12'h000, 12'(exp_q.size()));
    endtask : run_seq
    initial begin
        void'($urandom(88));
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        check("reset mask", 12'h000, 12'(sequence_channel_mask));
        host_bus_model_inst.write_mask(4'ha, 1'b0, 1'b1);
        check("mask", 12'h00a, 12'(sequence_channel_mask));
        host_bus_model_inst.write_mask(4'h5, 1'b1, 1'b1);
        check("mask", 12'h00a, 12'(sequence_channel_mask));
        host_bus_model_inst.write_mask(4'h5, 1'b0, 1'b0);
        check("mask", 12'h00a, 12'(sequence_channel_mask));
        run_seq(1'b0, 4'h0);
        run_seq(1'b1, 4'hf);
        run_seq(1'b0, 4'hd);
        run_seq(1'b1, 4'($urandom));
        run_seq(1'b0, 4'($urandom));
        finish_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule : adc_channel_sequence_select_tb
`default_nettype wire

// ### channel_picker.sv
// Finds the lowest selected channel at or above a starting index.
`timescale 1ns/1ns
`default_nettype none
`include "seq_select_defs.svh"
module channel_picker #(
    parameter int N = `NUM_CHANNELS
) (
    input wire logic [N-1:0] mask,
    input wire logic [$clog2(N)-1:0] from_idx,
    output logic found,
    output logic [$clog2(N)-1:0] pick_idx
);
    logic [N-1:0] eligible;

    if (N < 2) begin : g_bad_n
        $error("channel_picker needs at least two channels");
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            assign eligible[g] = mask[g] && (g >= int'(from_idx));
        end
    endgenerate

    // Scanning downward leaves the lowest eligible index, giving ascending order.
    always_comb begin
        found = 1'b0;
        pick_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                found = 1'b1;
                pick_idx = i[$clog2(N)-1:0];
            end
        end
    end
endmodule : channel_picker
`default_nettype wire

// ### host_bus_model.sv
// Host processor model that writes the channel mask over the low data lines.
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
    input wire logic core_clk,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [3:0] bus_line
);
    initial begin
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        bus_line = 4'h5;
    end
    // Each phase lasts four clocks so the synchronisers behind the pins see it.
    task automatic write_mask(input logic [3:0] value, input logic cs_n, input logic rd_n);
        @(negedge core_clk);
        chip_select_n = cs_n;
        read_strobe_n = rd_n;
        write_strobe_n = 1'b0;
        bus_line = value;
        repeat (4) @(negedge core_clk);
        write_strobe_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        // A released bus floats, so show the inverse rather than a stale value.
        bus_line = ~value;
        repeat (4) @(negedge core_clk);
    endtask : write_mask
endmodule : host_bus_model
`default_nettype wire

// ### seq_select.sv
// Conversion sequence selector: channel mask register, start latch and sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "seq_select_defs.svh"
module seq_select #(
    parameter seq_select_pkg::coding_type CODING = seq_select_pkg::coding_twos_comp,
    parameter int NUM_CHANNELS = `NUM_CHANNELS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic conversion_start_n,
    input wire logic source_select,
    input wire logic [3:0] hw_channel_pick,
    input wire logic [3:0] bus_line_in,
    input wire logic [`RESULT_W-1:0] sar_result,
    output logic sequence_active,
    output logic [3:0] latched_selection,
    output logic [3:0] sequence_channel_mask,
    output logic [`CHAN_IDX_W-1:0] converting_channel,
    output logic result_valid,
    output logic [`CHAN_IDX_W-1:0] result_channel,
    output logic [`RESULT_W-1:0] result_code
);
    // The index width and the 4-bit ports are fixed, so other counts are refused at elaboration.
    if (NUM_CHANNELS != `NUM_CHANNELS) begin : g_bad_channels
        $error("seq_select serves exactly four channels");
    end
    if (`CONV_CYCLES > (1 << `CONV_CNT_W)) begin : g_bad_count
        $error("conversion counter too narrow");
    end

    typedef enum {st_idle, st_convert} state_type;

    logic [1:0] rst_sync_q;
    logic rst_n;
    seq_select_pkg::pins_type pins_raw;
    seq_select_pkg::pins_type meta_q;
    seq_select_pkg::pins_type pins_q;
    logic wr_prev_q;
    logic start_prev_q;
    logic window_q, window_d;
    logic [3:0] hold_q, hold_d;
    logic [3:0] mask_q, mask_d;
    logic [3:0] sel_q, sel_d;
    state_type state_q, state_d;
    logic busy_q, busy_d;
    logic [`CHAN_IDX_W-1:0] chan_q, chan_d;
    logic [`CONV_CNT_W-1:0] cnt_q, cnt_d;
    logic valid_q, valid_d;
    seq_select_pkg::result_type res_q, res_d;
    logic [3:0] mux_sel;
    logic first_found, next_found;
    logic [`CHAN_IDX_W-1:0] first_idx, next_idx, next_from;
    logic last_chan;

    // Reset is released through two flops so all state leaves reset on one edge.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_comb begin
        pins_raw.cs_n = chip_select_n;
        pins_raw.rd_n = read_strobe_n;
        pins_raw.wr_n = write_strobe_n;
        pins_raw.start_n = conversion_start_n;
        pins_raw.source_select = source_select;
        pins_raw.picks = hw_channel_pick;
        pins_raw.bus = bus_line_in;
    end

    // Pins are asynchronous to core_clk, so each passes two flops first.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, start_n: 1'b1, default: '0};
            pins_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, start_n: 1'b1, default: '0};
            wr_prev_q <= 1'b1;
            start_prev_q <= 1'b1;
        end else begin
            meta_q <= pins_raw;
            pins_q <= meta_q;
            wr_prev_q <= pins_q.wr_n;
            start_prev_q <= pins_q.start_n;
        end
    end

    // Register write path.
    always_comb begin
        window_d = window_q;
        hold_d = hold_q;
        mask_d = mask_q;
        // The lines are inputs only while read is high and chip select, write are low.
        if (!pins_q.cs_n && !pins_q.wr_n && pins_q.rd_n) begin
            window_d = 1'b1;
            hold_d = pins_q.bus;
        end else if (!pins_q.wr_n) begin
            window_d = 1'b0;
        end
        // The value seen last before the strobe rises is the one kept.
        if (pins_q.wr_n && !wr_prev_q) begin
            window_d = 1'b0;
            if (window_q) begin
                mask_d = hold_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            window_q <= 1'b0;
            hold_q <= `MASK_RESET;
            mask_q <= `MASK_RESET;
        end else begin
            window_q <= window_d;
            hold_q <= hold_d;
            mask_q <= mask_d;
        end
    end

    // Low source select takes the pins, high takes the register.
    assign mux_sel = pins_q.source_select ? mask_q : pins_q.picks;

    assign next_from = chan_q + 2'(1);
    assign last_chan = (chan_q == `CHAN_IDX_W'(NUM_CHANNELS - 1));

    channel_picker #(
        .N(NUM_CHANNELS)
    ) u_first (
        .mask(mux_sel),
        .from_idx(`CHAN_IDX_W'(0)),
        .found(first_found),
        .pick_idx(first_idx)
    );

    channel_picker #(
        .N(NUM_CHANNELS)
    ) u_next (
        .mask(sel_q),
        .from_idx(next_from),
        .found(next_found),
        .pick_idx(next_idx)
    );

    // Sequencer. Starts arriving while a sequence runs are ignored.
    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        sel_d = sel_q;
        chan_d = chan_q;
        cnt_d = cnt_q;
        valid_d = 1'b0;
        res_d = res_q;
        unique case (state_q)
            st_idle: begin
                busy_d = 1'b0;
                if (pins_q.start_n && !start_prev_q) begin
                    sel_d = mux_sel;
                    busy_d = 1'b1;
                    // An empty selection still shows one cycle of activity.
                    if (first_found) begin
                        state_d = st_convert;
                        chan_d = first_idx;
                        cnt_d = '0;
                    end
                end
            end
            st_convert: begin
                if (cnt_q == `CONV_CNT_W'(`CONV_CYCLES - 1)) begin
                    valid_d = 1'b1;
                    res_d.channel = chan_q;
                    // The core delivers offset binary; flipping the sign bit gives twos complement.
                    if (CODING == seq_select_pkg::coding_twos_comp) begin
                        res_d.code = sar_result ^ (`RESULT_W'(1) << `SIGN_BIT);
                    end else begin
                        res_d.code = sar_result;
                    end
                    cnt_d = '0;
                    if (!last_chan && next_found) begin
                        chan_d = next_idx;
                    end else begin
                        state_d = st_idle;
                        busy_d = 1'b0;
                    end
                end else begin
                    cnt_d = cnt_q + `CONV_CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= st_idle;
            busy_q <= 1'b0;
            sel_q <= `MASK_RESET;
            chan_q <= '0;
            cnt_q <= '0;
            valid_q <= 1'b0;
            res_q <= '0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            sel_q <= sel_d;
            chan_q <= chan_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
            res_q <= res_d;
        end
    end

    assign sequence_active = busy_q;
    assign latched_selection = sel_q;
    assign sequence_channel_mask = mask_q;
    assign converting_channel = chan_q;
    assign result_valid = valid_q;
    assign result_channel = res_q.channel;
    assign result_code = res_q.code;
endmodule : seq_select
`default_nettype wire

// ### seq_select_checker.sv
// Assertion checker for the conversion sequence selector.
`timescale 1ns/1ns
`default_nettype none
module seq_select_checker #(
    parameter seq_select_pkg::coding_type CODING = seq_select_pkg::coding_twos_comp
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic write_strobe_n,
    input wire logic conversion_start_n,
    input wire logic source_select,
    input wire logic [3:0] hw_channel_pick,
    input wire logic [11:0] sar_result,
    input wire logic sequence_active,
    input wire logic [3:0] latched_selection,
    input wire logic [3:0] sequence_channel_mask,
    input wire logic [1:0] converting_channel,
    input wire logic result_valid,
    input wire logic [1:0] result_channel,
    input wire logic [11:0] result_code
);
    localparam logic [11:0] FLIP = (CODING == seq_select_pkg::coding_twos_comp) ? 12'h800 : 12'h0;
    logic [3:0] wr_age_q;
    logic [3:0] wr_age_d;
    // Counts clocks since the write strobe was last low, saturating.
    always_comb begin
        wr_age_d = (wr_age_q == 4'hf) ? wr_age_q : wr_age_q + 4'h1;
        if (!write_strobe_n) wr_age_d = 4'h0;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) wr_age_q <= 4'hf;
        else wr_age_q <= wr_age_d;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_first_result;
        ##[412:414] result_valid;
    endsequence
    property p_first_result;
        $rose(sequence_active) && latched_selection != 4'h0 |-> s_first_result;
    endproperty
    chk_first_result: assert property (p_first_result)
        else $error("first result out of time");
    chk_selection_held: assert property (sequence_active && $past(sequence_active)
        |-> $stable(latched_selection)) else $error("selection moved");
    chk_mask_write: assert property ($changed(sequence_channel_mask)
        |-> wr_age_q inside {[4'h1:4'h9]}) else $error("mask changed without write");
    chk_code_format: assert property (result_valid
        |-> result_code == ($past(sar_result) ^ FLIP)) else $error("bad code");
    chk_result_order: assert property (result_valid
        |-> result_channel == $past(converting_channel) && $past(sequence_active))
        else $error("bad result channel");
    chk_channel_rises: assert property (sequence_active && $past(sequence_active)
        && converting_channel != $past(converting_channel)
        |-> converting_channel > $past(converting_channel)) else $error("order broken");
    chk_channel_picked: assert property (sequence_active && latched_selection != 4'h0
        |-> latched_selection[converting_channel]) else $error("unselected channel");
    // Pins pass two synchroniser flops, while the register feeds the mux directly.
    chk_source_mux: assert property ($rose(sequence_active) |-> latched_selection ==
        ($past(source_select, 3) ? $past(sequence_channel_mask) : $past(hw_channel_pick, 3)))
        else $error("wrong source");
    chk_active_end: assert property ($fell(sequence_active)
        |-> result_valid || $past(latched_selection) == 4'h0) else $error("early end");
    chk_empty_pulse: assert property ($rose(sequence_active) && latched_selection == 4'h0
        |=> !sequence_active) else $error("empty sequence too long");
endmodule : seq_select_checker
bind seq_select seq_select_checker #(.CODING(CODING)) seq_select_checker_inst (.core_clk, .nrst,
    .write_strobe_n, .conversion_start_n, .source_select, .hw_channel_pick, .sar_result,
    .sequence_active, .latched_selection, .sequence_channel_mask, .converting_channel,
    .result_valid, .result_channel, .result_code);
`default_nettype wire

// ### seq_select_defs.svh
// Constants for the conversion sequence selector.
// Operation
// - Any subset of four channels, none to all, may form one sequence.
// - Selected channels convert in ascending order, unselected ones are skipped.
// - A channel joins when its pin or mask bit is one at start rise.
// - Source select steers a mux between select pins and the mask register.
// - Mux output is latched at start and held until the sequence ends.
// - Mask bit 0 is channel 1 up to bit 3 for channel 4, lines 0-3.
// - Low lines are register inputs while read high, chip select and write low.
// - The mask register captures the low lines on the write strobe rising edge.
// - Ten/five volt bipolar variant codes results as 12-bit twos complement.
// - Unipolar variant codes results as 12-bit straight binary.
// - Two and a half volt bipolar variant codes results as twos complement.
// - Source select low picks the pins, high picks the mask register.
// - Sequence active rises on the start edge and stays high until sequence end.
`ifndef SEQ_SELECT_DEFS_SVH
`define SEQ_SELECT_DEFS_SVH
`define NUM_CHANNELS 4
`define RESULT_W 12
`define CHAN_IDX_W 2
`define CLK_PERIOD_NS 4
`define CONV_TIME_NS 1650
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W 9
`define MASK_RESET 4'h0
`define SIGN_BIT 11
`endif

// ### seq_select_pkg.sv
// Types shared by the conversion sequence selector.
package seq_select_pkg;
    typedef enum {coding_twos_comp, coding_straight} coding_type;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic start_n;
        logic source_select;
        logic [3:0] picks;
        logic [3:0] bus;
    } pins_type;
    typedef struct packed {
        logic [1:0] channel;
        logic [11:0] code;
    } result_type;
endpackage : seq_select_pkg
